// file: brtc_count.sv
/*
 Running BCD calendar counters with second tick and parallel load.
 Assumes a one-cycle tick each second and a one-cycle load pulse.
*/
`timescale 1ns/10ps
`include "brtc_defs.svh"

module brtc_count (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic tick_i,
	input wire logic load_i,
	input wire brtc_pkg::brtc_time_t load_time_i,
	output brtc_pkg::brtc_time_t time_o
);
	brtc_pkg::brtc_time_t time_reg;
	brtc_pkg::brtc_time_t time_next;

	// Carry flag over next BCD value
	function automatic logic [8:0] bcd_step(input logic [7:0] v,
		input logic [7:0] first, input logic [7:0] last);
		if (v == last) begin
			bcd_step = {1'b1, first};
		end else if (v[3:0] == 4'h9) begin
			bcd_step = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_step = {1'b0, v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcd_step

	// BCD value divisible by four
	function automatic logic bcd_by4(input logic [7:0] v);
		if (v[4]) begin
			bcd_by4 = (v[3:0] == 4'h2) || (v[3:0] == 4'h6);
		end else begin
			bcd_by4 = (v[3:0] == 4'h0) || (v[3:0] == 4'h4) || (v[3:0] == 4'h8);
		end
	endfunction : bcd_by4

	// Month length, year 00 leaps by century
	wire leap = (time_reg.year == 8'h00) ? bcd_by4(time_reg.cent)
		: bcd_by4(time_reg.year);
	wire short_m = (time_reg.month == 8'h04) || (time_reg.month == 8'h06)
		|| (time_reg.month == 8'h09) || (time_reg.month == 8'h11);
	wire [7:0] date_last = (time_reg.month == 8'h02) ? (leap ? 8'h29 : 8'h28)
		: (short_m ? 8'h30 : 8'h31);

	// Carry chain, 24-hour BCD
	wire [8:0] s_sec = bcd_step(time_reg.sec, 8'h00, `BRTC_SEC_LAST);
	wire [8:0] s_min = bcd_step(time_reg.min, 8'h00, `BRTC_SEC_LAST);
	wire [8:0] s_hour = bcd_step(time_reg.hour, 8'h00, `BRTC_HOUR_LAST);
	wire [8:0] s_day = bcd_step(time_reg.day, 8'h01, `BRTC_DAY_LAST);
	wire [8:0] s_date = bcd_step(time_reg.date, 8'h01, date_last);
	wire [8:0] s_mon = bcd_step(time_reg.month, 8'h01, `BRTC_MONTH_LAST);
	wire [8:0] s_year = bcd_step(time_reg.year, 8'h00, `BRTC_YEAR_LAST);
	wire [8:0] s_cent = bcd_step(time_reg.cent, 8'h00, `BRTC_CENT_LAST);
	wire c_min = s_sec[8];
	wire c_hour = c_min & s_min[8];
	wire c_date = c_hour & s_hour[8];
	wire c_mon = c_date & s_date[8];
	wire c_year = c_mon & s_mon[8];
	wire c_cent = c_year & s_year[8];

	// Next value of each field on a tick
	always_comb begin
		time_next = time_reg;
		time_next.sec = s_sec[7:0];
		time_next.min = c_min ? s_min[7:0] : time_reg.min;
		time_next.hour = c_hour ? s_hour[7:0] : time_reg.hour;
		time_next.day = c_date ? s_day[7:0] : time_reg.day;
		time_next.date = c_date ? s_date[7:0] : time_reg.date;
		time_next.month = c_mon ? s_mon[7:0] : time_reg.month;
		time_next.year = c_year ? s_year[7:0] : time_reg.year;
		time_next.cent = c_cent ? s_cent[7:0] : time_reg.cent;
	end

	// Load wins over the tick
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			time_reg <= `BRTC_TIME_RESET;
		end else if (load_i) begin
			time_reg <= load_time_i;
		end else if (tick_i) begin
			time_reg <= time_next;
		end
	end

	assign time_o = time_reg;

	hour_range_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!load_i |=> time_reg.hour <= `BRTC_HOUR_LAST)
		else $error("hour left 24-hour range");
endmodule : brtc_count

// file: brtc_defs.svh
/*
 Constants for the byte-wide timekeeping RAM: map, fields, resets, timing.
 Assumes inclusion by every design file of the block; definitions only.
*/
// What this block does
// - 2k x 8 storage, clock in top eight
// - BCD century to seconds, 24-hour hours
// - month lengths and leap days automatic
// - visible registers separate from running counters
// - power fail blocks port, pins released
// - read bit set stops visible refresh
// - held registers keep time of hold
// - counters keep running during hold
// - refresh all together after hold clears
// - write bit stops refresh, host writes stick
// - write bit falling loads counters
// - one byte-wide port with strobes
// - read drives pins when select, enable low
// - write while select and strobe low
`ifndef BRTC_DEFS_SVH
`define BRTC_DEFS_SVH

// ---------------------------------------------
// Port and map
// ---------------------------------------------
`define BRTC_ADDR_W 11
`define BRTC_DATA_W 8
`define BRTC_CLK_PAGE 8'hFF
`define BRTC_IDX_CTRL 3'h0
`define BRTC_IDX_SEC 3'h1
`define BRTC_CTRL_WBIT 7
`define BRTC_CTRL_RBIT 6

// ---------------------------------------------
// Fields, bytes ordered year..century
// ---------------------------------------------
`define BRTC_FIELD_MASK 64'hFF1F3F073F7F7F3F
`define BRTC_TIME_RESET 64'h0001010100000020
`define BRTC_SEC_LAST 8'h59
`define BRTC_HOUR_LAST 8'h23
`define BRTC_DAY_LAST 8'h07
`define BRTC_MONTH_LAST 8'h12
`define BRTC_YEAR_LAST 8'h99
`define BRTC_CENT_LAST 8'h39

// ---------------------------------------------
// Timing
// ---------------------------------------------
`define BRTC_CLK_PERIOD_NS 40
`define BRTC_SECOND_NS 1000000000
`define BRTC_SEC_CYCLES (`BRTC_SECOND_NS / `BRTC_CLK_PERIOD_NS)
`define BRTC_TICK_W 25

`endif

// file: brtc_host.sv
/*
 Host model for the byte-wide timekeeping RAM: one read or write a call.
 Assumes a free-running clock; pins change at its falling edge.
*/
`timescale 1ns/10ps
`include "brtc_defs.svh"

module brtc_host (
	input wire logic clock_i,
	input wire logic dev_oe_i,
	input wire logic [7:0] bus_i,
	output logic cs_n_o,
	output logic oe_n_o,
	output logic we_n_o,
	output logic drive_o,
	output logic [`BRTC_ADDR_W-1:0] addr_o,
	output logic [7:0] wdata_o,
	output logic rd_valid_o,
	output logic [8:0] rd_data_o
);
	// Idle pins at time zero
	initial begin
		{cs_n_o, oe_n_o, we_n_o} = 3'h7;
		{drive_o, rd_valid_o} = 2'h0;
		addr_o = 11'h000;
		wdata_o = 8'h00;
		rd_data_o = 9'h000;
	end

	// Strobes low 4 cycles, address and data held 4 more
	task automatic write_byte(input logic [10:0] a, input logic [7:0] d);
		@(negedge clock_i);
		addr_o = a;
		wdata_o = d;
		drive_o = 1'b1;
		{cs_n_o, we_n_o} = 2'h0;
		repeat (4) @(negedge clock_i);
		{cs_n_o, we_n_o} = 2'h3;
		repeat (4) @(negedge clock_i);
		drive_o = 1'b0;
	endtask : write_byte

	// Select for 6 cycles, capture drive flag and byte, 3 idle
	task automatic read_byte(input logic [10:0] a, input logic oe_l);
		@(negedge clock_i);
		addr_o = a;
		{cs_n_o, oe_n_o} = {1'b0, oe_l};
		repeat (6) @(negedge clock_i);
		rd_data_o = {dev_oe_i, dev_oe_i ? bus_i : 8'h00};
		rd_valid_o = 1'b1;
		{cs_n_o, oe_n_o} = 2'h3;
		@(negedge clock_i);
		rd_valid_o = 1'b0;
		repeat (2) @(negedge clock_i);
	endtask : read_byte
endmodule : brtc_host

// file: brtc_pkg.sv
/*
 Types of the byte-wide timekeeping RAM.
 Assumes brtc_defs.svh for widths.
*/
`include "brtc_defs.svh"

package brtc_pkg;
	// Time bytes, century in the low byte
	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] min;
		logic [7:0] sec;
		logic [7:0] cent;
	} brtc_time_t;

	// Port pins after synchronising
	typedef struct packed {
		logic cs_n;
		logic oe_n;
		logic we_n;
		logic pf;
		logic [`BRTC_ADDR_W-1:0] addr;
		logic [`BRTC_DATA_W-1:0] din;
	} brtc_pins_t;

	typedef enum logic {ACC_IDLE, ACC_WRITE} brtc_acc_t;
endpackage : brtc_pkg

// file: brtc_ram.sv
/*
 2k x 8 storage with registered read data.
 Assumes one clock; write and read ports independent.
*/
`timescale 1ns/10ps
`include "brtc_defs.svh"

module brtc_ram (
	input wire logic clock_i,
	input wire logic we_i,
	input wire logic [`BRTC_ADDR_W-1:0] waddr_i,
	input wire logic [`BRTC_DATA_W-1:0] wdata_i,
	input wire logic [`BRTC_ADDR_W-1:0] raddr_i,
	output logic [`BRTC_DATA_W-1:0] rdata_o
);
	logic [`BRTC_DATA_W-1:0] mem [0:(1<<`BRTC_ADDR_W)-1];

	// Byte store and registered read
	always_ff @(posedge clock_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule : brtc_ram

// file: brtc_top.sv
/*
 Byte-wide timekeeping RAM: pin port, 2k byte store, double-buffered
 clock registers in the top eight bytes, second divider.
 Assumes the host drives the strobes asynchronously; every pin is
 synchronised here. One 25 MHz clock.
*/
`timescale 1ns/10ps
`include "brtc_defs.svh"

module brtc_top #(
	parameter int SEC_CYCLES = `BRTC_SEC_CYCLES
) (
	input wire logic clock_i,
	input wire logic rst_n_i,
	input wire logic [`BRTC_ADDR_W-1:0] address_pins_i,
	input wire logic [`BRTC_DATA_W-1:0] data_pins_i,
	output logic [`BRTC_DATA_W-1:0] data_pins_o,
	output logic data_pins_oe_o,
	input wire logic chip_select_n_i,
	input wire logic output_enable_n_i,
	input wire logic write_strobe_n_i,
	input wire logic power_fail_level_i
);
	// ---------------------------------------------
	// Declarations
	// ---------------------------------------------
	brtc_pkg::brtc_pins_t pin_raw;
	brtc_pkg::brtc_pins_t pin_meta_reg;
	brtc_pkg::brtc_pins_t pin_sync_reg;
	brtc_pkg::brtc_acc_t acc_reg;
	brtc_pkg::brtc_acc_t acc_next;
	brtc_pkg::brtc_time_t cnt_time;
	brtc_pkg::brtc_time_t vis_time;
	logic [`BRTC_ADDR_W-1:0] wr_addr_reg;
	logic [`BRTC_DATA_W-1:0] wr_data_reg;
	logic [`BRTC_DATA_W-1:0] ram_q;
	logic [`BRTC_DATA_W-1:0] vis_reg [0:7];
	logic [`BRTC_DATA_W-1:0] dout_reg;
	logic [2:0] rd_idx_reg;
	logic rd_clk_reg;
	logic hold_reg;
	logic wbit_reg;
	logic load_reg;
	logic load_next;
	logic [`BRTC_TICK_W-1:0] div_reg;
	logic tick;

	// Clock page decode, used by read and write paths
	function automatic logic is_clk(input logic [`BRTC_ADDR_W-1:0] a);
		is_clk = (a[`BRTC_ADDR_W-1:3] == `BRTC_CLK_PAGE);
	endfunction : is_clk

	// ---------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------

	// Gather pins into one carrier
	assign pin_raw.cs_n = chip_select_n_i;
	assign pin_raw.oe_n = output_enable_n_i;
	assign pin_raw.we_n = write_strobe_n_i;
	assign pin_raw.pf = power_fail_level_i;
	assign pin_raw.addr = address_pins_i;
	assign pin_raw.din = data_pins_i;

	// Two flops, idle strobes and power fail at reset
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_meta_reg <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, pf: 1'b1,
				addr: '0, din: '0};
			pin_sync_reg <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, pf: 1'b1,
				addr: '0, din: '0};
		end else begin
			pin_meta_reg <= pin_raw;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	// ---------------------------------------------
	// Access decode
	// ---------------------------------------------

	// Strobe states, power fail masks all
	wire pf = pin_sync_reg.pf;
	wire rd_cond = !pin_sync_reg.cs_n && !pin_sync_reg.oe_n
		&& pin_sync_reg.we_n && !pf;
	wire wr_cond = !pin_sync_reg.cs_n && !pin_sync_reg.we_n && !pf;
	wire wr_commit = (acc_reg == brtc_pkg::ACC_WRITE) && !wr_cond && !pf;
	wire host_wr = wr_commit && is_clk(wr_addr_reg);
	wire [2:0] wr_idx = wr_addr_reg[2:0];
	wire ctrl_wr = host_wr && (wr_idx == `BRTC_IDX_CTRL);
	wire ram_we = wr_commit && !is_clk(wr_addr_reg);

	// Write cycle tracking; the write lands at its end
	always_comb begin
		acc_next = acc_reg;
		unique case (acc_reg)
			brtc_pkg::ACC_IDLE: begin
				if (wr_cond) begin
					acc_next = brtc_pkg::ACC_WRITE;
				end
			end
			brtc_pkg::ACC_WRITE: begin
				if (!wr_cond) begin
					acc_next = brtc_pkg::ACC_IDLE;
				end
			end
		endcase
	end

	// State and latest address and data of the write
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_reg <= brtc_pkg::ACC_IDLE;
			wr_addr_reg <= '0;
			wr_data_reg <= '0;
		end else begin
			acc_reg <= acc_next;
			if (wr_cond) begin
				wr_addr_reg <= pin_sync_reg.addr;
				wr_data_reg <= pin_sync_reg.din;
			end
		end
	end

	// ---------------------------------------------
	// Storage
	// ---------------------------------------------
	brtc_ram u_ram (
		.clock_i(clock_i),
		.we_i(ram_we),
		.waddr_i(wr_addr_reg),
		.wdata_i(wr_data_reg),
		.raddr_i(pin_sync_reg.addr),
		.rdata_o(ram_q)
	);

	// ---------------------------------------------
	// Second divider and running counters
	// ---------------------------------------------

	// One-cycle tick each second; restarts on a load
	assign tick = (div_reg == `BRTC_TICK_W'(SEC_CYCLES - 1));

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_reg <= '0;
		end else if (tick || load_reg) begin
			div_reg <= '0;
		end else begin
			div_reg <= div_reg + `BRTC_TICK_W'(1);
		end
	end

	brtc_count u_count (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.tick_i(tick),
		.load_i(load_reg),
		.load_time_i(vis_time),
		.time_o(cnt_time)
	);

	// ---------------------------------------------
	// Visible clock registers
	// ---------------------------------------------

	// Refresh only when neither bit halts it
	wire copy_en = !hold_reg && !wbit_reg && !load_reg && !host_wr;
	wire [63:0] cnt_flat = cnt_time;
	wire [63:0] fmask = `BRTC_FIELD_MASK;
	localparam logic [63:0] VIS_RESET = `BRTC_TIME_RESET;
	wire [63:0] vis_flat;

	// One byte per location, separate from the counters
	for (genvar i = 0; i < 8; i++) begin : g_vis
		assign vis_flat[8*i +: 8] = vis_reg[i];
		always_ff @(posedge clock_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				vis_reg[i] <= VIS_RESET[8*i +: 8];
			end else if (host_wr && (wr_idx == 3'(i))) begin
				vis_reg[i] <= wr_data_reg & fmask[8*i +: 8];
			end else if (copy_en) begin
				vis_reg[i] <= cnt_flat[8*i +: 8];
			end
		end
	end

	assign vis_time = vis_flat;

	// Load pulse on the write bit going from 1 to 0
	assign load_next = ctrl_wr && wbit_reg
		&& !wr_data_reg[`BRTC_CTRL_WBIT];

	// Control bits of the century byte
	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hold_reg <= 1'b0;
			wbit_reg <= 1'b0;
			load_reg <= 1'b0;
		end else begin
			load_reg <= load_next;
			if (ctrl_wr) begin
				hold_reg <= wr_data_reg[`BRTC_CTRL_RBIT];
				wbit_reg <= wr_data_reg[`BRTC_CTRL_WBIT];
			end
		end
	end

	// ---------------------------------------------
	// Read path
	// ---------------------------------------------

	// Clock byte or memory byte, aligned with the RAM read
	wire [7:0] clk_byte = (rd_idx_reg == `BRTC_IDX_CTRL)
		? {wbit_reg, hold_reg, vis_reg[0][5:0]} : vis_reg[rd_idx_reg];
	wire [7:0] rd_byte = rd_clk_reg ? clk_byte : ram_q;

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_idx_reg <= '0;
			rd_clk_reg <= 1'b0;
			dout_reg <= '0;
		end else begin
			rd_idx_reg <= pin_sync_reg.addr[2:0];
			rd_clk_reg <= is_clk(pin_sync_reg.addr);
			dout_reg <= rd_byte;
		end
	end

	// Pins driven only in a read and never in power fail
	assign data_pins_o = dout_reg;
	assign data_pins_oe_o = rd_cond;

	// ---------------------------------------------
	// Checks
	// ---------------------------------------------
	sequence hold_released;
		$fell(hold_reg) && !wbit_reg && !load_reg;
	endsequence

	sequence quiet_cycle;
		!host_wr && !hold_reg && !wbit_reg && !load_reg;
	endsequence

	pf_quiet_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		pf |-> !data_pins_oe_o && !wr_commit && !ram_we)
		else $error("port active during power fail");

	drive_pins_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		data_pins_oe_o |-> $past(!chip_select_n_i, 2)
			&& $past(!output_enable_n_i, 2) && $past(write_strobe_n_i, 2))
		else $error("pins driven outside a read");

	write_end_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wr_commit |-> $past(!pin_sync_reg.cs_n && !pin_sync_reg.we_n)
			&& (pin_sync_reg.cs_n || pin_sync_reg.we_n))
		else $error("write landed outside a write cycle");

	hold_freeze_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		hold_reg && !host_wr && !load_reg |=> $stable(vis_flat))
		else $error("visible time moved during hold");

	count_runs_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		tick && !load_reg |=> cnt_time.sec != $past(cnt_time.sec))
		else $error("counter missed a second");

	refresh_all_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		hold_released ##1 quiet_cycle |=> vis_flat == $past(cnt_flat))
		else $error("visible registers not refreshed");

	load_copy_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		load_reg |=> cnt_flat == $past(vis_flat))
		else $error("counters not loaded from visible bytes");

	write_sticks_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		host_wr && wbit_reg && (wr_idx == `BRTC_IDX_SEC)
			|=> vis_reg[1] == $past(wr_data_reg & fmask[15:8]))
		else $error("host write to seconds lost");

	hold_stops_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		$rose(hold_reg) ##1 (hold_reg && !host_wr)[*2] |-> $stable(vis_flat))
		else $error("refresh ran with read bit set");

	wbit_freeze_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		wbit_reg && !host_wr && !load_reg |=> $stable(vis_flat))
		else $error("visible time moved with write bit set");

	refresh_cont_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		quiet_cycle |=> vis_flat == $past(cnt_flat))
		else $error("visible registers lag the counters");

	count_still_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		!tick && !load_reg |=> $stable(cnt_flat))
		else $error("counters moved without a tick");

	div_restart_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		load_reg |=> div_reg == '0)
		else $error("second divider not restarted by load");

	day_roll_a: assert property (@(posedge clock_i) disable iff (!rst_n_i)
		tick && !load_reg && (cnt_time.sec == `BRTC_SEC_LAST)
			&& (cnt_time.min == `BRTC_SEC_LAST) && (cnt_time.hour == `BRTC_HOUR_LAST)
			|=> (cnt_time.hour == 8'h00) && (cnt_time.day != $past(cnt_time.day)))
		else $error("day did not roll at midnight");
endmodule : brtc_top

// file: brtc_top_tb.sv
/*
 Self-checking bench of the byte-wide timekeeping RAM: RAM, power fail,
 clock set, read hold and leap handling. Assumes SEC_CYCLES of 20.
*/
`timescale 1ns/10ps
`include "brtc_defs.svh"

module brtc_top_tb;
	logic clock_i;
	logic rst_n_i = 1'b0;
	logic pf = 1'b0;
	logic [7:0] bus_last = 8'h00;
	logic [8:0] exp_q [$];
	logic [8:0] exp9;
	logic [31:0] lfsr = 32'h00016FAE; // Starts at 94126
	logic [10:0] ra [6];
	logic [7:0] rv [6];
	int mismatches = 0;
	int tests_run = 0;
	wire cs_n, oe_n, we_n, drv, dev_oe, rd_valid;
	wire [10:0] addr;
	wire [7:0] wd, dout;
	wire [8:0] rd_data;
	// Wire level: device, host, else a changing pattern
	wire [7:0] bus = dev_oe ? dout : (drv ? wd : ~bus_last);

	brtc_top #(.SEC_CYCLES(20)) brtc_top_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.address_pins_i(addr), .data_pins_i(bus), .data_pins_o(dout),
		.data_pins_oe_o(dev_oe), .chip_select_n_i(cs_n), .output_enable_n_i(oe_n),
		.write_strobe_n_i(we_n), .power_fail_level_i(pf));
	brtc_host brtc_host_inst (.clock_i(clock_i), .dev_oe_i(dev_oe), .bus_i(bus),
		.cs_n_o(cs_n), .oe_n_o(oe_n), .we_n_o(we_n), .drive_o(drv), .addr_o(addr),
		.wdata_o(wd), .rd_valid_o(rd_valid), .rd_data_o(rd_data));

	// ---------------------------------------------
	// Clock, wire history, result watcher
	// ---------------------------------------------
	initial begin
		clock_i = 1'b0;
		forever #20 clock_i = ~clock_i;
	end
	always @(posedge clock_i) bus_last <= bus;
	always @(posedge clock_i) begin
		if (rd_valid === 1'b1) begin
			exp9 = exp_q.pop_front();
			tests_run++;
			if (rd_data !== exp9) begin
				mismatches++;
				$display("wrong value at %0t: got %h expected %h", $time, rd_data, exp9);
			end
		end
	end

	// ---------------------------------------------
	// Helpers
	// ---------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr_next

	task automatic rd(input logic [10:0] a, input logic oe_l, input logic [8:0] e);
		exp_q.push_back(e);
		brtc_host_inst.read_byte(a, oe_l);
	endtask : rd

	task automatic wr(input logic [10:0] a, input logic [7:0] d);
		brtc_host_inst.write_byte(a, d);
	endtask : wr

	task automatic close_out;
		$display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : close_out

	// Load 23:59:59 Sat 28 Feb year 00, let one second pass, hold and read
	task automatic set_tick(input logic [7:0] c, input logic [7:0] dt, input logic [7:0] mo);
		logic [7:0] st [7];
		logic [7:0] ex [7];
		st = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h00};
		ex = '{8'h00, 8'h00, 8'h00, 8'h01, dt, mo, 8'h00};
		wr(11'h7F8, 8'h80 | c);
		for (int i = 0; i < 7; i++) wr(11'h7F9 + 11'(i), st[i]);
		rd(11'h7F9, 1'b0, 9'h159);
		wr(11'h7F8, 8'h40 | c);
		repeat (13) @(negedge clock_i);
		wr(11'h7F8, c);
		wr(11'h7F8, 8'h40 | c);
		for (int i = 0; i < 7; i++) rd(11'h7F9 + 11'(i), 1'b0, {1'b1, ex[i]});
		rd(11'h7F8, 1'b0, {1'b1, 8'h40 | c});
		repeat (3) @(negedge clock_i);
		wr(11'h7F8, c);
		wr(11'h7F8, 8'h40 | c);
		rd(11'h7F9, 1'b0, 9'h105);
		wr(11'h7F8, c);
	endtask : set_tick

	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		repeat (4) @(posedge clock_i);
		@(negedge clock_i);
		rst_n_i = 1'b1;
		repeat (3) @(negedge clock_i);
		rd(11'h7F8, 1'b0, 9'h120);
		rd(11'h7FB, 1'b0, 9'h100);
		rd(11'h7FD, 1'b0, 9'h101);
		// Random bytes in the plain store
		for (int i = 0; i < 6; i++) begin
			lfsr = lfsr_next(lfsr);
			ra[i] = {3'(i), lfsr[7:0]};
			rv[i] = lfsr[15:8];
			wr(ra[i], rv[i]);
		end
		for (int i = 0; i < 6; i++) rd(ra[i], 1'b0, {1'b1, rv[i]});
		// Power fail blocks both directions
		pf = 1'b1;
		repeat (3) @(negedge clock_i);
		wr(ra[0], ~rv[0]);
		rd(ra[0], 1'b0, 9'h000);
		pf = 1'b0;
		repeat (3) @(negedge clock_i);
		rd(ra[0], 1'b0, {1'b1, rv[0]});
		rd(ra[0], 1'b1, 9'h000);
		set_tick(8'h20, 8'h29, 8'h02);
		set_tick(8'h21, 8'h01, 8'h03);
		for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(posedge clock_i);
		if (exp_q.size() > 0) mismatches++;
		close_out();
	end

	// Hang guard
	initial begin
		repeat (5000) @(posedge clock_i);
		mismatches++;
		close_out();
	end
endmodule : brtc_top_tb
